//--- logic/pmt_defs.svh
// constants for the program memory / table read block
// assumes a single instruction clock shared with the processor core
`ifndef PMT_DEFS_SVH
`define PMT_DEFS_SVH

`define PMT_VEC_RST     12'h000
`define PMT_VEC_EXT     12'h004
`define PMT_VEC_TM0     12'h008
`define PMT_VEC_TM1     12'h00c
`define PMT_VEC_TB      12'h010

`define PMT_PC_MASK_1K  12'h3ff
`define PMT_PC_MASK_2K  12'h7ff
`define PMT_PC_MASK_4K  12'hfff
`define PMT_WORD_MASK14 15'h3fff
`define PMT_WORD_MASK15 15'h7fff
`define PMT_LAST_PAGE   4'hf

`define PMT_ADDR_TBLP   7'h07
`define PMT_ADDR_TABLE_UPPER_DATA   7'h08
`define PMT_ADDR_EDGE   7'h09
`define PMT_GP_BASE     7'h20
`define PMT_RAM_END_64  7'h40
`define PMT_RAM_END_96  7'h60
`define PMT_BANK1_END   7'h40
`define PMT_BANK1_OFS   7'h40

`define PMT_EDGE_RST    2'h1
`define PMT_TBLP_RST    8'h00
`define PMT_TABLE_UPPER_DATA_RST    8'h00

`endif

//--- logic/pmt_pkg.sv
// types for the program memory / table read block
// assumes pmt_defs.svh supplies the numeric constants
package pmt_pkg;

  typedef enum logic [2:0] {
    tr_idle  = 3'b001,
    tr_fetch = 3'b010,
    tr_write = 3'b100
  } pmt_tr_state_t;

  typedef enum logic [1:0] {
    edge_off  = 2'h0,
    edge_fall = 2'h1,
    edge_rise = 2'h2,
    edge_both = 2'h3
  } pmt_edge_t;

  typedef struct packed {
    logic [11:0]   pc;
    logic [14:0]   instr;
    logic [7:0]    table_address_pointer;
    logic [7:0]    table_upper_data;
    logic [1:0]    edge_select_control;
    logic          pin_q;
    logic [3:0]    pend;
    pmt_tr_state_t tr;
    logic [11:0]   tr_addr;
    logic [6:0]    tr_dest;
    logic [14:0]   tr_word;
    logic          taken;
    logic [11:0]   ret_pc;
    logic [7:0]    rdata;
  } pmt_core_state_t;

endpackage

//--- logic/pmt_data_ram.sv
// general purpose data RAM, 128 bytes of physical storage
// assumes the caller maps addresses and masks out-of-range accesses
`timescale 1ns/100ps
module pmt_data_ram (
  input  wire logic       clk,
  input  wire logic       we,
  input  wire logic [6:0] idx,
  input  wire logic [7:0] wdata,
  output logic [7:0]      rdata
);

  // volatile storage, no reset, like a real RAM
  logic [7:0] mem [0:127];

  assign rdata = mem[idx];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[idx] <= wdata;
    end
  end

endmodule

//--- logic/pmt_top.sv
// program memory, special entries, table read path and data memory map
// assumes the core holds off data accesses while tbl_busy is high
`timescale 1ns/100ps
`include "pmt_defs.svh"
module pmt_top #(
  parameter int unsigned VARIANT = 2
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        pm_wr,
  input  wire logic [11:0] pm_waddr,
  input  wire logic [14:0] pm_wdata,
  input  wire logic        pc_inc,
  input  wire logic        pc_load,
  input  wire logic [11:0] pc_load_addr,
  output logic [11:0]      pc,
  output logic [14:0]      instr,
  input  wire logic        ext_int_pin,
  input  wire logic        tmr0_ovf,
  input  wire logic        tmr1_ovf,
  input  wire logic        tb_ovf,
  input  wire logic [3:0]  int_en,
  input  wire logic        int_window,
  input  wire logic        stack_full,
  output logic             int_taken,
  output logic [11:0]      int_ret_pc,
  input  wire logic        read_table_current_page,
  input  wire logic        read_table_last_page,
  input  wire logic [6:0]  tbl_dest,
  output logic             tbl_busy,
  output logic             tbl_done,
  input  wire logic        dm_rd,
  input  wire logic        dm_wr,
  input  wire logic        dm_bset,
  input  wire logic        dm_bclr,
  input  wire logic [2:0]  dm_bit,
  input  wire logic        dm_ind,
  input  wire logic        dm_bank,
  input  wire logic [6:0]  dm_addr,
  input  wire logic [7:0]  dm_wdata,
  output logic [7:0]       dm_rdata
);

  localparam logic [11:0] PMASK = (VARIANT == 0) ? `PMT_PC_MASK_1K :
                                  (VARIANT == 1) ? `PMT_PC_MASK_2K : `PMT_PC_MASK_4K;
  localparam logic [14:0] WMASK = (VARIANT == 0) ? `PMT_WORD_MASK14 : `PMT_WORD_MASK15;
  localparam logic [6:0]  B0END = (VARIANT == 0) ? `PMT_RAM_END_64 : `PMT_RAM_END_96;
  localparam pmt_pkg::pmt_core_state_t RST = '{
    pc:                    `PMT_VEC_RST,
    table_address_pointer: `PMT_TBLP_RST,
    table_upper_data:      `PMT_TABLE_UPPER_DATA_RST,
    edge_select_control:   `PMT_EDGE_RST,
    tr:                    pmt_pkg::tr_idle,
    default:               '0
  };

  // result: {hit, physical index}; bank 1 only exists on the largest variant
  function automatic logic [7:0] ram_map(input logic [6:0] a, input logic bank);
    logic [7:0] r;
    r = 8'h00;
    if (bank && VARIANT == 2) begin
      if (a >= `PMT_GP_BASE && a < `PMT_BANK1_END) begin
        r = {1'b1, 7'(a + `PMT_BANK1_OFS)};
      end
    end else if (a >= `PMT_GP_BASE && a < B0END) begin
      r = {1'b1, a};
    end
    return r;
  endfunction

  // fixed priority: external, counter 0, counter 1, time base
  function automatic logic [11:0] entry_of(input logic [3:0] g);
    logic [11:0] v;
    v = `PMT_VEC_TB;
    if (g[0]) begin
      v = `PMT_VEC_EXT;
    end else if (g[1]) begin
      v = `PMT_VEC_TM0;
    end else if (g[2]) begin
      v = `PMT_VEC_TM1;
    end
    return v;
  endfunction

  function automatic logic [3:0] first_of(input logic [3:0] g);
    return g & (~g + 4'h1);
  endfunction

  logic [1:0]                rsync;
  logic                      rst_n;
  pmt_pkg::pmt_core_state_t  s;
  pmt_pkg::pmt_core_state_t  next_s;
  logic [14:0]               rom [0:4095];
  logic [14:0]               fetch_q;
  logic [14:0]               tbl_q;
  logic [3:0]                counter_upper_bits;
  logic                      acc_tbl;
  logic [6:0]                acc_addr;
  logic                      acc_bank;
  logic [7:0]                map;
  logic [7:0]                ram_q;
  logic [7:0]                cur;
  logic [7:0]                bmask;
  logic [7:0]                newv;
  logic                      do_wr;
  logic                      ram_we;
  logic                      rise;
  logic                      fall;
  logic [3:0]                set_ev;
  logic [3:0]                grant;
  logic                      take;

  // the first stage feeds only the second
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rsync <= 2'b00;
    end else begin
      rsync <= {rsync[0], 1'b1};
    end
  end
  assign rst_n = rsync[1];

  // otp image, loaded by the programming port; unused upper word bits held at zero
  always_ff @(posedge clk) begin
    if (pm_wr) begin
      rom[pm_waddr & PMASK] <= pm_wdata & WMASK;
    end
  end
  assign fetch_q            = rom[s.pc];
  assign tbl_q              = rom[s.tr_addr];
  assign counter_upper_bits = s.pc[11:8];

  pmt_data_ram u_ram (
    .clk   (clk),
    .we    (ram_we),
    .idx   (map[6:0]),
    .wdata (newv),
    .rdata (ram_q)
  );

  always_comb begin
    next_s       = s;
    next_s.taken = 1'b0;

    // data memory access: table commit has the port, else the core
    acc_tbl  = (s.tr == pmt_pkg::tr_write);
    acc_addr = acc_tbl ? s.tr_dest : dm_addr;
    acc_bank = !acc_tbl && dm_ind && dm_bank;
    map      = ram_map(acc_addr, acc_bank);
    if (map[7]) begin
      cur = ram_q;
    end else if (acc_addr == `PMT_ADDR_TBLP) begin
      cur = s.table_address_pointer;
    end else if (acc_addr == `PMT_ADDR_TABLE_UPPER_DATA) begin
      cur = s.table_upper_data;
    end else if (acc_addr == `PMT_ADDR_EDGE) begin
      cur = {6'h00, s.edge_select_control};
    end else begin
      cur = 8'h00;
    end
    bmask = 8'(8'h01 << dm_bit);
    if (acc_tbl) begin
      newv = s.tr_word[7:0];
    end else if (dm_wr) begin
      newv = dm_wdata;
    end else if (dm_bset) begin
      newv = cur | bmask;
    end else if (dm_bclr) begin
      newv = cur & ~bmask;
    end else begin
      newv = cur;
    end
    do_wr  = acc_tbl || dm_wr || dm_bset || dm_bclr;
    ram_we = do_wr && map[7];
    if (do_wr && !map[7] && acc_addr == `PMT_ADDR_TBLP) begin
      next_s.table_address_pointer = newv;
    end
    // holding register has no write path from the data side
    if (do_wr && !map[7] && acc_addr == `PMT_ADDR_EDGE) begin
      next_s.edge_select_control = newv[1:0];
    end
    if (dm_rd) begin
      next_s.rdata = cur;
    end

    // interrupt sources; a set in the clearing cycle survives
    rise         = ext_int_pin && !s.pin_q;
    fall         = !ext_int_pin && s.pin_q;
    next_s.pin_q = ext_int_pin;
    set_ev = {tb_ovf, tmr1_ovf, tmr0_ovf,
              (rise && s.edge_select_control[1]) || (fall && s.edge_select_control[0])};
    grant  = s.pend & int_en;
    // a full stack leaves the request pending until a return frees a level
    take   = int_window && !stack_full && (|grant) && (s.tr == pmt_pkg::tr_idle);
    next_s.pend = (s.pend & ~(take ? first_of(grant) : 4'h0)) | set_ev;

    if (take) begin
      next_s.pc     = entry_of(grant);
      next_s.taken  = 1'b1;
      next_s.ret_pc = s.pc;
    end else if (pc_load) begin
      next_s.pc = pc_load_addr & PMASK;
    end else if (pc_inc) begin
      next_s.pc = (s.pc + 12'h001) & PMASK;
    end
    next_s.instr = fetch_q;

    unique case (s.tr)
      pmt_pkg::tr_idle: begin
        if (read_table_current_page || read_table_last_page) begin
          next_s.tr      = pmt_pkg::tr_fetch;
          next_s.tr_dest = tbl_dest;
          if (read_table_last_page) begin
            next_s.tr_addr = {`PMT_LAST_PAGE, s.table_address_pointer} & PMASK;
          end else begin
            next_s.tr_addr = {counter_upper_bits, s.table_address_pointer} & PMASK;
          end
        end
      end
      pmt_pkg::tr_fetch: begin
        next_s.tr_word = tbl_q;
        next_s.tr      = pmt_pkg::tr_write;
      end
      pmt_pkg::tr_write: begin
        next_s.table_upper_data = {1'b0, s.tr_word[14:8]};
        next_s.tr               = pmt_pkg::tr_idle;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= RST;
    end else begin
      s <= next_s;
    end
  end

  assign pc         = s.pc;
  assign instr      = s.instr;
  assign int_taken  = s.taken;
  assign int_ret_pc = s.ret_pc;
  assign tbl_busy   = (s.tr != pmt_pkg::tr_idle);
  assign tbl_done   = (s.tr == pmt_pkg::tr_write);
  assign dm_rdata   = s.rdata;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_tbl_go;
    s.tr == pmt_pkg::tr_idle && (read_table_current_page || read_table_last_page);
  endsequence
  sequence s_tbl_finish;
    ##1 tbl_busy && !tbl_done ##1 tbl_done ##1 !tbl_busy;
  endsequence

  chk_reset_entry: assert property (
    $rose(rst_n) |-> pc == `PMT_VEC_RST && !int_taken)
    else $error("pc not at reset entry after reset");
  chk_ext_vector: assert property (
    take && grant[0] |=> pc == `PMT_VEC_EXT && int_taken && int_ret_pc == $past(s.pc))
    else $error("external interrupt entry not taken");
  chk_edge_capture: assert property (
    s.edge_select_control == 2'h2 && !s.pin_q && ext_int_pin |=> s.pend[0])
    else $error("rising edge not recorded");
  chk_counter_vector: assert property (
    take && grant[1:0] == 2'h2 |=> pc == `PMT_VEC_TM0)
    else $error("counter 0 entry not taken");
  chk_stack_hold: assert property (
    stack_full |=> !int_taken)
    else $error("interrupt taken with full stack");
  chk_tbl_cur_addr: assert property (
    s.tr == pmt_pkg::tr_idle && read_table_current_page && !read_table_last_page
    |=> s.tr_addr == ({$past(counter_upper_bits), $past(s.table_address_pointer)} & PMASK))
    else $error("current page table address wrong");
  chk_tbl_last_addr: assert property (
    s.tr == pmt_pkg::tr_idle && read_table_last_page
    |=> s.tr_addr == ({`PMT_LAST_PAGE, $past(s.table_address_pointer)} & PMASK))
    else $error("last page table address wrong");
  chk_tbl_two: assert property (
    s_tbl_go |-> s_tbl_finish)
    else $error("table read not two cycles");
  chk_table_upper_data_zero: assert property (
    !s.table_upper_data[7] && (VARIANT != 0 || !s.table_upper_data[6]))
    else $error("unused holding bits not zero");
  chk_table_upper_data_ro: assert property (
    s.tr != pmt_pkg::tr_write |=> $stable(s.table_upper_data))
    else $error("holding register changed outside table read");
  chk_tbl_low_ptr: assert property (
    s_tbl_go |=> s.tr_addr[7:0] == $past(s.table_address_pointer))
    else $error("table address low byte not the pointer");
  chk_tm1_vector: assert property (
    take && grant[2:0] == 3'h4 |=> pc == `PMT_VEC_TM1 && int_taken)
    else $error("counter 1 entry not taken");
  chk_tb_vector: assert property (
    take && grant == 4'h8 |=> pc == `PMT_VEC_TB && int_taken)
    else $error("time base entry not taken");
  chk_pend_kept: assert property (
    stack_full && s.pend[3] |=> s.pend[3])
    else $error("time base request lost while stack full");
  chk_busy_no_int: assert property (
    tbl_busy |=> !int_taken)
    else $error("interrupt entered during table read");
  chk_unused_zero: assert property (
    dm_rd && !tbl_done && dm_addr > `PMT_ADDR_EDGE && dm_addr < `PMT_GP_BASE
    |=> dm_rdata == 8'h00)
    else $error("unused special location not zero");

endmodule

//--- dv/pmt_core_model.sv
// core stand-in: interrupt window and a bounded return stack
// assumes one instruction clock; pushes on int_taken, pops on pop
`timescale 1ns/100ps
module pmt_core_model #(
  parameter int unsigned DEPTH = 6
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic tbl_busy,
  input  wire logic int_taken,
  input  wire logic pop,
  output logic      int_window,
  output logic      stack_full
);
  int unsigned sp;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sp <= 0;
    end else if (int_taken && !pop && sp < DEPTH) begin
      sp <= sp + 1;
    end else if (pop && !int_taken && sp > 0) begin
      sp <= sp - 1;
    end
  end
  // no interrupt slot while a table read owns the data path
  assign int_window = !tbl_busy;
  assign stack_full = (sp == DEPTH);
endmodule

//--- dv/test_pmt_top.sv
// bench for pmt_top: reset, data map, table reads, special entries
// assumes pmt_core_model stands for the processor core
`timescale 1ns/100ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin fails++; \
  $display("Error %0t: got %h exp %h", $time, got, exp); end end
module test_pmt_top;
  logic        clk, rstn, pm_wr, pc_load, ext_int_pin, tmr0_ovf, tmr1_ovf, tb_ovf, pop;
  logic        int_window, stack_full, int_taken, rtc, rtl, tbl_busy, tbl_done;
  logic        dm_rd, dm_wr, dm_bset, dm_bclr, dm_ind, dm_bank, pc_inc;
  logic [11:0] pm_waddr, pc_load_addr, pc, int_ret_pc;
  logic [14:0] pm_wdata, instr;
  logic [3:0]  int_en;
  logic [6:0]  tbl_dest, dm_addr;
  logic [7:0]  dm_wdata, dm_rdata;
  logic [2:0]  dm_bit;
  int          fails, cmp_count;

  pmt_top #(.VARIANT(2)) u_dut (.clk(clk), .rstn(rstn), .pm_wr(pm_wr), .pm_waddr(pm_waddr),
    .pm_wdata(pm_wdata), .pc_inc(pc_inc), .pc_load(pc_load), .pc_load_addr(pc_load_addr),
    .pc(pc), .instr(instr), .ext_int_pin(ext_int_pin), .tmr0_ovf(tmr0_ovf),
    .tmr1_ovf(tmr1_ovf), .tb_ovf(tb_ovf), .int_en(int_en), .int_window(int_window),
    .stack_full(stack_full), .int_taken(int_taken), .int_ret_pc(int_ret_pc),
    .read_table_current_page(rtc), .read_table_last_page(rtl), .tbl_dest(tbl_dest),
    .tbl_busy(tbl_busy), .tbl_done(tbl_done), .dm_rd(dm_rd), .dm_wr(dm_wr),
    .dm_bset(dm_bset), .dm_bclr(dm_bclr), .dm_bit(dm_bit), .dm_ind(dm_ind),
    .dm_bank(dm_bank), .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_rdata(dm_rdata));

  // small depth so the full-stack case is reached quickly
  pmt_core_model #(.DEPTH(5)) u_core (.clk(clk), .rstn(rstn), .tbl_busy(tbl_busy),
    .int_taken(int_taken), .pop(pop), .int_window(int_window), .stack_full(stack_full));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // op is {rd, wr, bset, bclr}
  task automatic dm(input logic [3:0] op, input logic ind, bank, input logic [6:0] a,
                    input logic [7:0] d, input logic [2:0] b);
    @(posedge clk);
    {dm_rd, dm_wr, dm_bset, dm_bclr} <= op;
    dm_ind <= ind;
    dm_bank <= bank;
    dm_addr <= a;
    dm_wdata <= d;
    dm_bit <= b;
    @(posedge clk);
    {dm_rd, dm_wr, dm_bset, dm_bclr} <= 4'h0;
    #1;
  endtask

  task automatic rdc(input logic ind, bank, input logic [6:0] a, input logic [7:0] exp);
    dm(4'h8, ind, bank, a, 8'h00, 3'h0);
    `CHK(dm_rdata, exp)
  endtask

  task automatic pmw(input logic [11:0] a, input logic [14:0] d);
    @(posedge clk);
    pm_wr <= 1'b1;
    pm_waddr <= a;
    pm_wdata <= d;
    @(posedge clk);
    pm_wr <= 1'b0;
  endtask

  task automatic tbl(input logic last, input logic [6:0] dest);
    @(posedge clk);
    rtl <= last;
    rtc <= !last;
    tbl_dest <= dest;
    @(posedge clk);
    rtl <= 1'b0;
    rtc <= 1'b0;
    #1 `CHK({tbl_busy, tbl_done}, 2'b10)
    @(posedge clk);
    #1 `CHK({tbl_busy, tbl_done}, 2'b11)
    @(posedge clk);
    #1 `CHK({tbl_busy, tbl_done}, 2'b00)
  endtask

  task automatic fire(input int k);
    @(posedge clk);
    {tb_ovf, tmr1_ovf, tmr0_ovf} <= 3'(1 << k);
    @(posedge clk);
    {tb_ovf, tmr1_ovf, tmr0_ovf} <= 3'h0;
  endtask

  task automatic take(input logic [11:0] entry);
    int          n;
    logic [11:0] prev;
    n = 0;
    prev = pc;
    while (int_taken !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1 n++;
    end
    `CHK(int_taken, 1'b1)
    `CHK(pc, entry)
    `CHK(int_ret_pc, prev)
  endtask

  task automatic t_reset();
    `CHK(pc, 12'h000)
    rdc(0, 0, 7'h07, 8'h00);
    rdc(0, 0, 7'h08, 8'h00);
    rdc(0, 0, 7'h09, 8'h01);
    $display("test reset done");
  endtask

  task automatic t_data();
    dm(4'h4, 0, 0, 7'h20, 8'h5a, 3'h0);
    dm(4'h2, 0, 0, 7'h20, 8'h00, 3'h0);
    dm(4'h1, 0, 0, 7'h20, 8'h00, 3'h6);
    rdc(0, 0, 7'h20, 8'h1b);
    dm(4'h4, 1, 1, 7'h20, 8'h33, 3'h0);
    rdc(0, 1, 7'h20, 8'h1b);
    rdc(1, 1, 7'h20, 8'h33);
    dm(4'h4, 0, 0, 7'h5f, 8'hc3, 3'h0);
    rdc(0, 0, 7'h5f, 8'hc3);
    dm(4'h4, 0, 0, 7'h08, 8'hff, 3'h0);
    rdc(0, 0, 7'h08, 8'h00);
    rdc(0, 0, 7'h10, 8'h00);
    $display("test data done");
  endtask

  task automatic t_table();
    pmw(12'hf06, 15'h7fbc);
    pmw(12'h306, 15'h2e01);
    pmw(12'h3f0, 15'h1234);
    @(posedge clk);
    pc_load <= 1'b1;
    pc_load_addr <= 12'h3f0;
    @(posedge clk);
    pc_load <= 1'b0;
    #1 `CHK(pc, 12'h3f0)
    @(posedge clk);
    #1 `CHK(instr, 15'h1234)
    @(posedge clk);
    pc_inc <= 1'b1;
    @(posedge clk);
    pc_inc <= 1'b0;
    #1 `CHK(pc, 12'h3f1)
    dm(4'h4, 0, 0, 7'h07, 8'h06, 3'h0);
    rdc(0, 0, 7'h07, 8'h06);
    tbl(1'b1, 7'h21);
    rdc(0, 0, 7'h21, 8'hbc);
    rdc(0, 0, 7'h08, 8'h7f);
    tbl(1'b0, 7'h22);
    rdc(0, 0, 7'h22, 8'h01);
    rdc(0, 0, 7'h08, 8'h2e);
    $display("test table done");
  endtask

  task automatic t_irq();
    for (int m = 1; m < 4; m++) begin
      dm(4'h4, 0, 0, 7'h09, 8'(m), 3'h0);
      rdc(0, 0, 7'h09, 8'(m));
      @(posedge clk);
      ext_int_pin <= ~ext_int_pin;
      take(12'h004);
    end
    // counter 0 masked: the request must wait for its enable
    @(posedge clk);
    int_en <= 4'hd;
    fire(0);
    repeat (4) begin
      @(posedge clk);
      #1 `CHK(int_taken, 1'b0)
    end
    @(posedge clk);
    int_en <= 4'hf;
    take(12'h008);
    fire(1);
    take(12'h00c);
    fire(2);
    // stack is full now: the request must wait, not vanish
    repeat (6) begin
      @(posedge clk);
      #1 `CHK(int_taken, 1'b0)
    end
    @(posedge clk);
    pop <= 1'b1;
    @(posedge clk);
    pop <= 1'b0;
    take(12'h010);
    $display("test irq done");
  endtask

  task automatic t_rst2();
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    #1 `CHK(pc, 12'h000)
    `CHK(int_taken, 1'b0)
    rdc(0, 0, 7'h07, 8'h00);
    rdc(0, 0, 7'h08, 8'h00);
    rdc(0, 0, 7'h09, 8'h01);
    $display("test second reset done");
  endtask

  initial begin
    #(100 * 5000);
    fails++;
    wrap_up();
  end

  initial begin
    fails = 0;
    cmp_count = 0;
    rstn = 1'b0;
    {pm_wr, pc_load, tmr0_ovf, tmr1_ovf, tb_ovf, pop, rtc, rtl} = '0;
    {dm_rd, dm_wr, dm_bset, dm_bclr, dm_ind, dm_bank, pc_inc} = '0;
    ext_int_pin = 1'b1;
    int_en = 4'hf;
    {pm_waddr, pc_load_addr, pm_wdata} = '0;
    {tbl_dest, dm_addr, dm_wdata, dm_bit} = '0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    t_reset();
    t_data();
    t_table();
    t_irq();
    t_rst2();
    wrap_up();
  end
endmodule
